/* inc/idma_pkg.sv */
package idma_pkg;

	// ----------------------------------------------------------------
	// i/o decode windows of the two controllers
	// ----------------------------------------------------------------
	localparam logic [15:0] IO1_LO = 16'h0000;
	localparam logic [15:0] IO1_HI = 16'h000f;
	localparam logic [15:0] IO2_LO = 16'h00c0;
	localparam logic [15:0] IO2_HI = 16'h00de;

	// ----------------------------------------------------------------
	// channel mode byte layout
	// ----------------------------------------------------------------
	localparam int MODE_LSB = 6;
	localparam int TYPE_LSB = 2;
	localparam int DEC_BIT = 5;
	localparam logic [1:0] MODE_DEMAND = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam logic [1:0] MODE_CASCADE = 2'h3;
	localparam logic [1:0] TYPE_VERIFY = 2'h0;
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_READ = 2'h2;

	// ----------------------------------------------------------------
	// sizes, reset values and timing
	// ----------------------------------------------------------------
	localparam int NCHAN = 8;
	localparam int CASC_CHAN = 4;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_LAST = 16'h0000;
	localparam int CMD_NS = 20;
	localparam int CLK_NS = 10;
	localparam logic [1:0] CMD_CYCLES = 2'((CMD_NS + CLK_NS - 1) / CLK_NS);
	localparam int EV_W = 19;
	localparam int EV_DEPTH = 16;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_HOLD = 6'b000010,
		ST_SETUP = 6'b000100,
		ST_CMD = 6'b001000,
		ST_DONE = 6'b010000,
		ST_CASC = 6'b100000
	} idma_state_t;

endpackage : idma_pkg

/* logic/idma_top.sv */
// Functional notes
// R1 - i/o 000h..00fh selects controller one; its channels move bytes only
// R2 - i/o 0c0h..0deh selects controller two; its channels move 16-bit words
// R3 - controller two channel 0 carries every controller one request to the bus
// R4 - mode bits 7:6 pick demand 00, single 01, block 10, cascade 11
// R5 - demand keeps transferring while drq holds, releases on drop, stops at tc
// R6 - single does one transfer per request, count down, address up or down
// R7 - terminal count pulses when the word count wraps from 0000h to ffffh
// R8 - peripheral holds drq until dack arrives in single mode
// R9 - single mode needs drq dropped and raised again; bus released between
// R10 - block runs from one drq until tc, refresh locked out meanwhile
// R11 - peripheral keeps drq until dack in block mode; software uses block sparingly
// R12 - cascade grants the bus while drq holds, no counting, no strobes
// R13 - external master drives the command strobes itself during cascade
// R14 - address outputs float whenever the external master signal is active
// R15 - type bits 3:2 code 00 is verify, no command strobe asserted
// R16 - type 01 writes memory from i/o: i/o read plus memory write
// R17 - type 10 reads memory to i/o: memory read plus i/o write
// R18 - fixed priority favours channel 0; rotating puts last serviced lowest
// R19 - dack goes only to the single winning channel, after bus is held
`timescale 1ns/1ps

module idma_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} idma_fifo_st_t;

	idma_fifo_st_t q_r, q_nxt;
	logic push, take;

	// output stage is its own register so the drain side sees flops only
	always_comb
	begin
		q_nxt = q_r;
		push = in_valid_i && (q_r.cnt < (AW+1)'(D));
		take = (q_r.cnt != '0) && (!q_r.ov || out_ready_i);
		if (push)
		begin
			q_nxt.mem[q_r.wp] = in_data_i;
			q_nxt.wp = q_r.wp + 1'b1;
		end
		if (take)
		begin
			q_nxt.od = q_r.mem[q_r.rp];
			q_nxt.rp = q_r.rp + 1'b1;
			q_nxt.ov = 1'b1;
		end
		else if (out_ready_i)
		begin
			q_nxt.ov = 1'b0;
		end
		q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(take);
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			q_r <= '0;
		end
		else
		begin
			q_r <= q_nxt;
		end
	end

	assign in_ready_o = q_r.cnt < (AW+1)'(D);
	assign out_valid_o = q_r.ov;
	assign out_data_o = q_r.od;

endmodule : idma_fifo

module idma_top (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// bus pins, asynchronous
	input wire logic [idma_pkg::NCHAN-1:0] drq_i,
	input wire logic master_n_i,
	input wire logic hlda_i,
	// configuration, same clock
	input wire logic [15:0] io_addr_i,
	input wire logic [idma_pkg::NCHAN*8-1:0] mode_i,
	input wire logic [idma_pkg::NCHAN-1:0] mask_i,
	input wire logic [1:0] rotate_i,
	input wire logic ld_i,
	input wire logic [2:0] ld_chan_i,
	input wire logic [15:0] ld_cnt_i,
	input wire logic [15:0] ld_addr_i,
	// bus side outputs
	output logic hrq_o,
	output logic [idma_pkg::NCHAN-1:0] dack_n_o,
	output logic tc_o,
	output logic ior_n_o,
	output logic iow_n_o,
	output logic memr_n_o,
	output logic memw_n_o,
	output logic cmd_oe_n_o,
	output logic [15:0] addr_o,
	output logic addr_oe_n_o,
	output logic word16_o,
	output logic refresh_lock_o,
	output logic dec_ctl1_o,
	output logic dec_ctl2_o,
	// transfer event stream
	output logic ev_valid_o,
	output logic [idma_pkg::EV_W-1:0] ev_data_o,
	input wire logic ev_ready_i
);
	import idma_pkg::*;

	typedef struct packed {
		logic [NCHAN-1:0] drq_m, drq_s;
		logic mst_m, mst_s, hlda_m, hlda_s;
		idma_state_t st;
		logic [2:0] chan;
		logic [1:0] cmd_cnt;
		logic [NCHAN-1:0][15:0] cnt;
		logic [NCHAN-1:0][15:0] adr;
		logic [NCHAN-1:0] armed;
		logic [1:0] last1, last2;
		logic hrq, tc, ior_n, iow_n, memr_n, memw_n, cmd_oe_n, addr_oe_n;
		logic [NCHAN-1:0] dack_n;
		logic [15:0] addr;
		logic word16, lock, dec1, dec2, push;
		logic [EV_W-1:0] push_data;
	} idma_st_t;

	idma_st_t r, n;
	logic fifo_rdy;
	logic [NCHAN-1:0] elig;
	logic [1:0] w1, w2, cmode, ctype;
	logic [2:0] win;
	logic win_ok;
	logic setup_go;

	// a push still in flight is not yet in the fill count, so wait for it to land
	assign setup_go = fifo_rdy && !r.push;

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	function automatic logic [1:0] idma_pick(input logic [3:0] req, input logic rot,
		input logic [1:0] last);
		logic [1:0] idx;
		logic [1:0] res;
		logic hit;
		res = 2'h0;
		hit = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			idx = rot ? 2'(last + 2'(i) + 2'h1) : 2'(i);
			if (req[idx] && !hit)
			begin
				res = idx;
				hit = 1'b1;
			end
		end
		return res;
	endfunction : idma_pick

	// single mode channels must be re-armed by a low drq first
	always_comb
	begin
		for (int i = 0; i < NCHAN; i++)
		begin
			elig[i] = r.drq_s[i] && !mask_i[i]
				&& (mode_i[i*8+MODE_LSB +: 2] != MODE_SINGLE || r.armed[i]); // see R9
		end
		elig[CASC_CHAN] = (|elig[3:0]) && !mask_i[CASC_CHAN]; // see R3
		w1 = idma_pick(elig[3:0], rotate_i[0], r.last1); // see R18
		w2 = idma_pick(elig[7:4], rotate_i[1], r.last2); // see R18
		win = (w2 == 2'h0) ? {1'b0, w1} : {1'b1, w2}; // see R3
		win_ok = |elig[7:4];
		cmode = mode_i[r.chan*8+MODE_LSB +: 2]; // see R4
		ctype = mode_i[r.chan*8+TYPE_LSB +: 2]; // see R15
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.drq_m = drq_i;
		n.drq_s = r.drq_m;
		n.mst_m = !master_n_i;
		n.mst_s = r.mst_m;
		n.hlda_m = hlda_i;
		n.hlda_s = r.hlda_m;
		n.tc = 1'b0;
		n.push = 1'b0;
		n.dec1 = io_addr_i >= IO1_LO && io_addr_i <= IO1_HI; // see R1
		n.dec2 = io_addr_i >= IO2_LO && io_addr_i <= IO2_HI; // see R2
		for (int i = 0; i < NCHAN; i++)
		begin
			if (!r.drq_s[i])
			begin
				n.armed[i] = 1'b1;
			end
		end
		if (ld_i)
		begin
			n.cnt[ld_chan_i] = ld_cnt_i;
			n.adr[ld_chan_i] = ld_addr_i;
		end
		case (r.st)
			ST_IDLE:
			begin
				// no new grant while the queue is full or the last hold is still acknowledged
				if (win_ok && fifo_rdy && !r.hlda_s) // see R19
				begin
					n.chan = win;
					n.hrq = 1'b1;
					n.st = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (r.hlda_s)
				begin
					n.dack_n[r.chan] = 1'b0; // see R19
					n.word16 = r.chan[2]; // see R1, R2
					n.lock = (cmode == MODE_BLOCK); // see R10
					n.addr = r.adr[r.chan];
					n.st = (cmode == MODE_CASCADE) ? ST_CASC : ST_SETUP; // see R12
				end
			end
			ST_SETUP:
			begin
				if (setup_go)
				begin
					n.cmd_oe_n = 1'b0;
					n.ior_n = !(ctype == TYPE_WRITE); // see R16
					n.memw_n = !(ctype == TYPE_WRITE); // see R16
					n.memr_n = !(ctype == TYPE_READ); // see R17
					n.iow_n = !(ctype == TYPE_READ); // see R17
					n.cmd_cnt = CMD_CYCLES - 2'h1;
					n.st = ST_CMD;
				end
				else if (cmode == MODE_DEMAND && !r.drq_s[r.chan])
				begin
					// a stalled demand channel gives the bus back once its request drops
					n.st = ST_IDLE; // see R5
				end
			end
			ST_CMD:
			begin
				if (r.cmd_cnt == 2'h0)
				begin
					n.ior_n = 1'b1;
					n.iow_n = 1'b1;
					n.memr_n = 1'b1;
					n.memw_n = 1'b1;
					n.st = ST_DONE;
				end
				else
				begin
					n.cmd_cnt = r.cmd_cnt - 2'h1;
				end
			end
			ST_DONE:
			begin
				// counters move at the end of each transfer
				n.cnt[r.chan] = r.cnt[r.chan] - 16'h0001; // see R6
				n.adr[r.chan] = mode_i[r.chan*8+DEC_BIT] ? r.adr[r.chan] - 16'h0001
					: r.adr[r.chan] + 16'h0001; // see R6
				n.addr = n.adr[r.chan];
				n.tc = (r.cnt[r.chan] == CNT_LAST); // see R7
				n.push = 1'b1;
				n.push_data = {r.chan, r.adr[r.chan]};
				if (r.chan[2])
				begin
					n.last2 = r.chan[1:0];
				end
				else
				begin
					n.last1 = r.chan[1:0];
					n.last2 = 2'h0;
				end
				n.st = ST_SETUP;
				if (cmode == MODE_SINGLE)
				begin
					n.armed[r.chan] = 1'b0; // see R9
					n.st = ST_IDLE; // see R6
				end
				else if (n.tc || (cmode == MODE_DEMAND && !r.drq_s[r.chan]))
				begin
					n.st = ST_IDLE; // see R5, R10
				end
			end
			ST_CASC:
			begin
				if (!r.drq_s[r.chan])
				begin
					n.st = ST_IDLE; // see R12
				end
			end
			default:
			begin
				n.st = ST_IDLE;
			end
		endcase
		// releasing the bus drops every grant at once
		if (n.st == ST_IDLE)
		begin
			n.hrq = 1'b0;
			n.dack_n = '1;
			n.cmd_oe_n = 1'b1;
			n.lock = 1'b0;
		end
		n.addr_oe_n = r.mst_s || !(n.st inside {ST_SETUP, ST_CMD, ST_DONE}); // see R14
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			r <= '0;
			r.st <= ST_IDLE;
			r.cnt <= {NCHAN{CNT_RST}};
			r.ior_n <= 1'b1;
			r.iow_n <= 1'b1;
			r.memr_n <= 1'b1;
			r.memw_n <= 1'b1;
			r.cmd_oe_n <= 1'b1;
			r.addr_oe_n <= 1'b1;
			r.dack_n <= '1;
		end
		else
		begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// event queue, back-pressure stalls new grants
	// ----------------------------------------------------------------
	idma_fifo #(.W(EV_W), .D(EV_DEPTH)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(r.push),
		.in_data_i(r.push_data),
		.in_ready_o(fifo_rdy),
		.out_valid_o(ev_valid_o),
		.out_data_o(ev_data_o),
		.out_ready_i(ev_ready_i)
	);

	assign hrq_o = r.hrq;
	assign dack_n_o = r.dack_n;
	assign tc_o = r.tc;
	assign ior_n_o = r.ior_n;
	assign iow_n_o = r.iow_n;
	assign memr_n_o = r.memr_n;
	assign memw_n_o = r.memw_n;
	assign cmd_oe_n_o = r.cmd_oe_n;
	assign addr_o = r.addr;
	assign addr_oe_n_o = r.addr_oe_n;
	assign word16_o = r.word16;
	assign refresh_lock_o = r.lock;
	assign dec_ctl1_o = r.dec1;
	assign dec_ctl2_o = r.dec2;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	property p_dec1;
		io_addr_i <= IO1_HI |=> dec_ctl1_o;
	endproperty
	a_dec1: assert property (p_dec1) else $error("ctl1 decode missed"); // see R1
	property p_dec2;
		io_addr_i >= IO2_LO && io_addr_i <= IO2_HI |=> dec_ctl2_o && !dec_ctl1_o;
	endproperty
	a_dec2: assert property (p_dec2) else $error("ctl2 decode missed"); // see R2
	property p_tc;
		r.st == ST_DONE && r.cnt[r.chan] == CNT_LAST |=> tc_o ##1 !tc_o;
	endproperty
	a_tc: assert property (p_tc) else $error("tc not pulsed on wrap"); // see R7
	property p_single;
		r.st == ST_DONE && cmode == MODE_SINGLE |=> !hrq_o && dack_n_o == '1;
	endproperty
	a_single: assert property (p_single) else $error("bus kept after single"); // see R9
	property p_verify;
		r.st == ST_CMD && ctype == TYPE_VERIFY |-> ior_n_o && iow_n_o && memr_n_o && memw_n_o;
	endproperty
	a_verify: assert property (p_verify) else $error("strobe during verify"); // see R15
	property p_write;
		r.st == ST_SETUP && setup_go && ctype == TYPE_WRITE |=> (!ior_n_o && !memw_n_o) [*2];
	endproperty
	a_write: assert property (p_write) else $error("write strobes wrong"); // see R16
	property p_read;
		r.st == ST_SETUP && setup_go && ctype == TYPE_READ |=> !memr_n_o && !iow_n_o && ior_n_o;
	endproperty
	a_read: assert property (p_read) else $error("read strobes wrong"); // see R17
	property p_master;
		r.mst_s |=> addr_oe_n_o;
	endproperty
	a_master: assert property (p_master) else $error("address driven under master"); // see R14
	property p_dack;
		$onehot0(~dack_n_o) && (dack_n_o == '1 || hrq_o);
	endproperty
	a_dack: assert property (p_dack) else $error("dack not unique or unheld"); // see R19
	property p_casc;
		r.st == ST_CASC |-> cmd_oe_n_o && $stable(r.cnt);
	endproperty
	a_casc: assert property (p_casc) else $error("cascade touched count"); // see R12

endmodule : idma_top

/* tb/idma_peer.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: peripherals, cpu hold logic, external master
// ----------------------------------------------------------------
module idma_peer (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// bench control
	input wire logic [7:0] want_i,
	input wire logic hold_i,
	input wire logic stop_i,
	input wire logic [7:0] casc_i,
	// bus side
	input wire logic hrq_i,
	input wire logic [7:0] dack_n_i,
	output logic [7:0] drq_o,
	output logic hlda_o,
	output logic master_n_o
);
	// request stays up until dack; hold keeps it up to provoke a second grant
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			drq_o <= 8'h00;
			hlda_o <= 1'b0;
			master_n_o <= 1'b1;
		end
		else
		begin
			drq_o <= (drq_o | want_i) & ~((~dack_n_i & {8{~hold_i}}) | {8{stop_i}});
			hlda_o <= hrq_i; // cpu side grants one cycle late
			master_n_o <= ~|(casc_i & ~dack_n_i);
		end
	end
endmodule : idma_peer

/* tb/tb_idma_top.sv */
`timescale 1ns/1ps
module tb_idma_top;
	import idma_pkg::*;
	logic clk_sys_i, reset_n_i, hlda_i, master_n_i, ld_i, ev_ready_i, hold, stop, w16, lk;
	logic [7:0] drq_i, mask_i, want, casc, dack_n_o;
	logic [15:0] io_addr_i, ld_cnt_i, ld_addr_i, addr_o, a;
	logic [63:0] mode_i;
	logic [1:0] rotate_i;
	logic [2:0] ld_chan_i;
	logic hrq_o, tc_o, ior_n_o, iow_n_o, memr_n_o, memw_n_o, cmd_oe_n_o, addr_oe_n_o;
	logic word16_o, refresh_lock_o, dec_ctl1_o, dec_ctl2_o, ev_valid_o;
	logic [EV_W-1:0] ev_data_o;
	logic [3:0] strb;
	logic [16:0] seen_ad;
	logic [EV_W-1:0] exp_q[$];
	int n_fail, compares, n_tc, seed, i, ch;

	idma_top dut_u (.clk_sys_i, .reset_n_i, .drq_i, .master_n_i, .hlda_i, .io_addr_i,
		.mode_i, .mask_i, .rotate_i, .ld_i, .ld_chan_i, .ld_cnt_i, .ld_addr_i, .hrq_o,
		.dack_n_o, .tc_o, .ior_n_o, .iow_n_o, .memr_n_o, .memw_n_o, .cmd_oe_n_o, .addr_o,
		.addr_oe_n_o, .word16_o, .refresh_lock_o, .dec_ctl1_o, .dec_ctl2_o, .ev_valid_o,
		.ev_data_o, .ev_ready_i);
	idma_peer peer_u (.clk_sys_i, .reset_n_i, .want_i(want), .hold_i(hold), .stop_i(stop),
		.casc_i(casc), .hrq_i(hrq_o), .dack_n_i(dack_n_o), .drq_o(drq_i), .hlda_o(hlda_i),
		.master_n_o(master_n_i));

	// free running 100 mhz clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick

	// program one channel and queue the events the model predicts
	task automatic prep(input int c, input logic [1:0] md, input logic [1:0] ty,
		input logic [15:0] cnt, input int n);
		a = 16'($random(seed));
		mode_i[c*8 +: 8] = {md, 2'h0, ty, 2'h0};
		ld_chan_i = 3'(c);
		ld_cnt_i = cnt;
		ld_addr_i = a;
		ld_i = 1'b1;
		tick(1);
		ld_i = 1'b0;
		for (int k = 0; k < n; k++)
			exp_q.push_back({3'(c), a + 16'(k)});
	endtask : prep

	// raise requests, wait for all predicted events and bus release
	task automatic go(input logic [7:0] w, input int lim);
		int t;
		strb = 4'h0;
		n_tc = 0;
		w16 = 1'b0;
		lk = 1'b0;
		want = w;
		tick(1);
		want = 8'h00;
		for (t = 0; t < lim && (exp_q.size() != 0 || hrq_o !== 1'b0); t++)
			tick(1);
		if (t >= lim)
			check("wait_done", 0, 1);
		tick(4);
	endtask : go

	// event scoreboard and strobe watch; the fifo must keep the model's order
	always @(posedge clk_sys_i)
	begin
		if (ev_valid_o === 1'b1 && ev_ready_i)
		begin
			if (exp_q.size() == 0)
				check("ev_extra", 0, 1);
			else
				check("ev_data", 32'(ev_data_o), 32'(exp_q.pop_front()));
		end
		n_tc += int'(tc_o === 1'b1);
		if (dack_n_o !== 8'hff)
			w16 |= word16_o;
		if (refresh_lock_o === 1'b1)
			lk = 1'b1;
		strb |= ~{ior_n_o, iow_n_o, memr_n_o, memw_n_o};
		if (cmd_oe_n_o === 1'b0)
			seen_ad = {addr_oe_n_o, addr_o};
	end

	// watchdog, far above the expected run time
	initial
	begin
		#300000;
		n_fail++;
		report_and_stop();
	end

	initial
	begin
		seed = 32'h27e4552b;
		{reset_n_i, ld_i, hold, stop, rotate_i, ld_chan_i, ld_cnt_i, ld_addr_i} = '0;
		{want, casc, mask_i, mode_i, io_addr_i} = '0;
		ev_ready_i = 1'b1;
		tick(3);
		check("reset", {hrq_o, dack_n_o, tc_o, addr_oe_n_o, ev_valid_o}, 12'h7fa);
		reset_n_i = 1'b1;
		// decode edges of both windows plus random addresses
		for (i = 0; i < 12; i++)
		begin
			a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h000f : (i == 2) ? 16'h0010
				: (i == 3) ? 16'h00bf : (i == 4) ? 16'h00c0 : (i == 5) ? 16'h00de
				: (i == 6) ? 16'h00df : 16'($random(seed));
			io_addr_i = a;
			tick(1);
			check("decode", {dec_ctl1_o, dec_ctl2_o}, {a <= 16'h000f,
				a >= 16'h00c0 && a <= 16'h00de});
		end
		// one single transfer per type, byte and word channels
		for (i = 0; i < 3; i++)
		begin
			ch = (i == 0) ? 2 : i + 5;
			prep(ch, MODE_SINGLE, 2'(i), 16'h0000, 1);
			go(8'(1 << ch), 100);
			check("strobes", strb, (i == 0) ? 4'h0 : (i == 1) ? 4'h9 : 4'h6);
			check("tc", n_tc, 1);
			check("word16", w16, ch > 4);
			check("addr", seen_ad, {1'b0, a});
		end
		// request held through the cycle gives one transfer only
		prep(6, MODE_SINGLE, TYPE_WRITE, 16'h0005, 1);
		hold = 1'b1;
		go(8'h40, 100);
		tick(40);
		stop = 1'b1;
		hold = 1'b0;
		tick(1);
		stop = 1'b0;
		check("single_tc", n_tc, 0);
		// block from one request runs to terminal count
		prep(5, MODE_BLOCK, TYPE_WRITE, 16'h0002, 3);
		go(8'h20, 200);
		check("block_tc", n_tc, 1);
		check("block_lock", lk, 1);
		check("block_addr", seen_ad, {1'b0, a + 16'h0002});
		// fixed priority across the cascade slot, then rotating
		prep(1, MODE_SINGLE, TYPE_READ, 16'h0000, 1);
		for (i = 5; i < 8; i++)
			prep(i, MODE_SINGLE, TYPE_READ, 16'h0000, 1);
		go(8'he2, 300);
		check("prio_tc", n_tc, 4);
		rotate_i = 2'b10;
		prep(5, MODE_SINGLE, TYPE_WRITE, 16'h0000, 1);
		go(8'h20, 100);
		prep(6, MODE_SINGLE, TYPE_WRITE, 16'h0000, 1);
		prep(5, MODE_SINGLE, TYPE_WRITE, 16'h0000, 1);
		go(8'h60, 200);
		rotate_i = 2'b00;
		// masked channel is never granted
		mask_i = 8'h80;
		prep(7, MODE_SINGLE, TYPE_WRITE, 16'h0000, 1);
		want = 8'h80;
		tick(1);
		want = 8'h00;
		tick(30);
		check("masked_hrq", hrq_o, 0);
		mask_i = 8'h00;
		go(8'h00, 100);
		// cascade: bus held while drq holds, address released to the master
		prep(6, MODE_CASCADE, TYPE_WRITE, 16'h0000, 0);
		casc = 8'h40;
		hold = 1'b1;
		strb = 4'h0;
		want = 8'h40;
		tick(1);
		want = 8'h00;
		for (i = 0; i < 40 && dack_n_o[6] !== 1'b0; i++)
			tick(1);
		tick(8);
		check("casc_dack", dack_n_o, 8'hbf);
		check("casc_addr_oe_n", addr_oe_n_o, 1);
		check("casc_strobes", strb, 0);
		check("casc_cmd_oe_n", cmd_oe_n_o, 1);
		stop = 1'b1;
		hold = 1'b0;
		tick(1);
		stop = 1'b0;
		tick(8);
		check("casc_release", dack_n_o, 8'hff);
		casc = 8'h00;
		// demand into a stalled fifo: queue depth plus the output stage, then refusal
		ev_ready_i = 1'b0;
		prep(5, MODE_DEMAND, TYPE_READ, 16'h0013, EV_DEPTH + 1);
		hold = 1'b1;
		want = 8'h20;
		tick(1);
		want = 8'h00;
		tick(300);
		check("fifo_full_valid", ev_valid_o, 1);
		stop = 1'b1;
		hold = 1'b0;
		tick(1);
		stop = 1'b0;
		tick(10);
		check("demand_release", hrq_o, 0);
		for (i = 0; i < 500 && exp_q.size() != 0; i++)
		begin
			ev_ready_i = 1'($random(seed));
			tick(1);
		end
		ev_ready_i = 1'b1;
		tick(20);
		check("fifo_left", exp_q.size(), 0);
		check("fifo_empty", ev_valid_o, 0);
		report_and_stop();
	end
endmodule : tb_idma_top
